// ---- inc/iop_cfg.svh ----
// Purpose: constants for the I/O port register block
// Assumes: 8-bit I/O address space, four GPIO ports
// Notes:   offsets are I/O addresses as the core issues them
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH

// address map
`define IOP_DATA_BASE   8'h00
`define IOP_DATA_LAST   8'h03
`define IOP_IRQEN_BASE  8'h04
`define IOP_IRQEN_LAST  8'h07

// structure
`define IOP_NUM_PORTS   4
`define IOP_PAR_PORT    2
`define IOP_PAR_LSB     2
`define IOP_PAR_MSB     6
`define IOP_PAR_WIDTH   5

// reset and read-back values
`define IOP_DATA_RST    8'h00
`define IOP_IRQEN_RST   8'h00
`define IOP_NODATA_RD   8'h00

`endif

// ---- inc/iop_pkg.sv ----
// Purpose: shared types of the I/O port register block
// Assumes: included after iop_cfg.svh where constants are needed
// Notes:   types only, constants live in the header
package iop_pkg;

  typedef logic [7:0] iop_byte_t;

  // access kind decoded from the instruction strobes
  typedef enum logic [1:0] {
    IOP_OP_NONE,
    IOP_OP_READ,
    IOP_OP_WRITE,
    IOP_OP_IDXWRITE
  } iop_op_t;

endpackage

// ---- src/iop_port.sv ----
// Purpose: data and interrupt-enable storage for one GPIO port
// Assumes: write strobes are one-cycle pulses already decoded
// Notes:   the enable register has no read path of its own
`timescale 1ns/1ps
`default_nettype none
`include "iop_cfg.svh"

module iop_port (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // write side
  input  wire logic          dataWe,
  input  wire logic          irqWe,
  input  wire iop_pkg::iop_byte_t wrData,
  // stored values
  output var  iop_pkg::iop_byte_t dataQ,
  output var  iop_pkg::iop_byte_t irqEnQ
);
  import iop_pkg::*;

  iop_byte_t data_d;
  iop_byte_t irqEn_d;

  // next values: hold unless the matching strobe fires
  always_comb begin
    data_d  = dataQ;
    irqEn_d = irqEnQ;
    if (dataWe) begin
      data_d = wrData;
    end
    // RQ7: store enable mask
    if (irqWe) begin
      irqEn_d = wrData;
    end
  end

  // register the port state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dataQ  <= `IOP_DATA_RST;
      irqEnQ <= `IOP_IRQEN_RST;
    end else begin
      dataQ  <= data_d;
      irqEnQ <= irqEn_d;
    end
  end

endmodule
`default_nettype wire

// ---- src/iop_regs.sv ----
// Purpose: decode and access of I/O addresses 0x00 to 0x07
// Assumes: the core raises at most one instruction strobe per cycle
// Notes:   pin outputs and read data are registered, one cycle late
//
// How it works
// RQ1: a direct read copies the addressed register into the accumulator.
// RQ2: a direct write stores the accumulator at the instruction address.
// RQ3: indexed write targets instruction address plus index, then writes.
// RQ4: indexed write with address zero selects by index alone.
// RQ5: firmware writes zero into every reserved bit position.
// RQ6: firmware never writes undefined or reserved I/O addresses.
// RQ7: each port has a write-only pin interrupt enable at 0x04 to 0x07.
// RQ8: port two bits six to two also serve the assisted parallel port.
// RQ9: reading an enable address gives a fixed value, no side effect.
`timescale 1ns/1ps
`default_nettype none
`include "iop_cfg.svh"

module iop_regs (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // instruction strobes from the core, one-cycle pulses
  input  wire logic               ioReadInstr,
  input  wire logic               ioWriteInstr,
  input  wire logic               indexedIoWriteInstr,
  // operands from the core
  input  wire iop_pkg::iop_byte_t instrAddr,
  input  wire iop_pkg::iop_byte_t indexReg,
  input  wire iop_pkg::iop_byte_t accIn,
  // read answer to the core
  output var  iop_pkg::iop_byte_t accOut,
  output var  logic               accLoad,
  // gpio pins, port n in bits 8n+7 to 8n
  input  wire logic [31:0]        pinIn,
  output var  logic [31:0]        pinOut,
  // per-pin interrupt enables, same packing
  output var  logic [31:0]        pinIrqEnable,
  // assisted parallel port on port two
  input  wire logic               assistedParallelPortEn,
  input  wire logic [4:0]         assistedParallelPortOut,
  output var  logic [4:0]         assistedParallelPortIn
);
  import iop_pkg::*;

  // decoded access
  iop_op_t   op;
  iop_byte_t targetAddr;
  logic      isData;
  logic      isIrqEn;
  logic      wrAny;
  logic [1:0] portSel;

  // per-port write strobes and stored values
  logic [`IOP_NUM_PORTS-1:0] dataWe;
  logic [`IOP_NUM_PORTS-1:0] irqWe;
  iop_byte_t portData  [`IOP_NUM_PORTS];
  iop_byte_t portIrqEn [`IOP_NUM_PORTS];

  // registered outputs
  iop_byte_t   accOut_q;
  iop_byte_t   accOut_d;
  logic        accLoad_q;
  logic        accLoad_d;
  logic [31:0] pinOut_q;
  logic [31:0] pinOut_d;
  logic [31:0] irqEn_q;
  logic [31:0] irqEn_d;
  logic [4:0]  parIn_q;
  logic [4:0]  parIn_d;

  // classify the strobes; read has priority if several arrive
  always_comb begin
    if (ioReadInstr) begin
      op = IOP_OP_READ;
    end else if (ioWriteInstr) begin
      op = IOP_OP_WRITE;
    end else if (indexedIoWriteInstr) begin
      op = IOP_OP_IDXWRITE;
    end else begin
      op = IOP_OP_NONE;
    end
  end

  // form the target address
  always_comb begin
    case (op)
      // RQ3: address plus index
      // RQ4: zero address leaves index
      IOP_OP_IDXWRITE: begin
        targetAddr = instrAddr + indexReg; // wraps in eight bits
      end
      default: begin
        targetAddr = instrAddr;
      end
    endcase
  end

  // address window decode
  always_comb begin
    // data window starts at address zero, so only its top end is tested
    isData  = (targetAddr <= `IOP_DATA_LAST);
    isIrqEn = (targetAddr >= `IOP_IRQEN_BASE) &&
              (targetAddr <= `IOP_IRQEN_LAST);
    portSel = targetAddr[1:0];
    wrAny   = (op == IOP_OP_WRITE) || (op == IOP_OP_IDXWRITE);
  end

  // one-hot write strobes; addresses above 0x07 write nothing
  always_comb begin
    dataWe = '0;
    irqWe  = '0;
    for (int i = 0; i < `IOP_NUM_PORTS; i++) begin
      // RQ2: direct write strobe
      if (wrAny && isData && (portSel == i[1:0])) begin
        dataWe[i] = 1'b1;
      end
      // RQ7: enable write strobe
      if (wrAny && isIrqEn && (portSel == i[1:0])) begin
        irqWe[i] = 1'b1;
      end
    end
  end

  // one storage slice per port
  genvar g;
  generate
    for (g = 0; g < `IOP_NUM_PORTS; g++) begin : gPort
      iop_port uPort (
        .clk    (clk),
        .rstn   (rstn),
        .dataWe (dataWe[g]),
        .irqWe  (irqWe[g]),
        .wrData (accIn),
        .dataQ  (portData[g]),
        .irqEnQ (portIrqEn[g])
      );
    end
  endgenerate

  // read path into the accumulator
  always_comb begin
    accOut_d  = accOut_q;
    accLoad_d = 1'b0;
    if (op == IOP_OP_READ) begin
      accLoad_d = 1'b1;
      // RQ1: copy addressed register
      if (isData) begin
        accOut_d = portData[portSel];
      // RQ9: enables not readable
      end else begin
        accOut_d = `IOP_NODATA_RD;
      end
    end
  end

  // pin drive, with port two shared by the parallel port
  always_comb begin
    pinOut_d = '0;
    irqEn_d  = '0;
    for (int i = 0; i < `IOP_NUM_PORTS; i++) begin
      pinOut_d[i*8 +: 8] = portData[i];
      irqEn_d[i*8 +: 8]  = portIrqEn[i];
    end
    // RQ8: parallel port overrides
    if (assistedParallelPortEn) begin
      pinOut_d[`IOP_PAR_PORT*8+`IOP_PAR_LSB +: `IOP_PAR_WIDTH] =
        assistedParallelPortOut;
    end
    // RQ8: parallel port samples
    parIn_d = pinIn[`IOP_PAR_PORT*8+`IOP_PAR_LSB +: `IOP_PAR_WIDTH];
  end

  // register everything that leaves the block
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accOut_q  <= `IOP_NODATA_RD;
      accLoad_q <= 1'b0;
      pinOut_q  <= '0;
      irqEn_q   <= '0;
      parIn_q   <= '0;
    end else begin
      accOut_q  <= accOut_d;
      accLoad_q <= accLoad_d;
      pinOut_q  <= pinOut_d;
      irqEn_q   <= irqEn_d;
      parIn_q   <= parIn_d;
    end
  end

  // outputs straight from flops
  assign accOut                 = accOut_q;
  assign accLoad                = accLoad_q;
  assign pinOut                 = pinOut_q;
  assign pinIrqEnable           = irqEn_q;
  assign assistedParallelPortIn = parIn_q;

endmodule
`default_nettype wire

// ---- tb/iop_regs_chk.sv ----
// Purpose: port checks of the I/O register block
// Assumes: strobes are one-cycle pulses
// Notes: bound to every iop_regs instance
`timescale 1ns/1ps
`default_nettype none
module iop_regs_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // core side
  input wire logic ioReadInstr,
  input wire logic ioWriteInstr,
  input wire logic indexedIoWriteInstr,
  input wire iop_pkg::iop_byte_t instrAddr,
  input wire iop_pkg::iop_byte_t indexReg,
  input wire iop_pkg::iop_byte_t accIn,
  input wire iop_pkg::iop_byte_t accOut,
  input wire logic accLoad,
  // pins
  input wire logic [31:0] pinIn,
  input wire logic [31:0] pinOut,
  input wire logic [31:0] pinIrqEnable,
  input wire logic assistedParallelPortEn,
  input wire logic [4:0] assistedParallelPortOut,
  input wire logic [4:0] assistedParallelPortIn
);
  import iop_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // read answers
  AST_RD_DATA:
    assert property (ioReadInstr && instrAddr == 8'h00 |=> accLoad
      ##1 pinOut[7:0] == $past(accOut)) else $error("read data");
  AST_NO_LOAD:
    assert property (!ioReadInstr |=> !accLoad) else $error("stray load");
  // writes reach the pins two edges on
  AST_WR_DIRECT:
    assert property (ioWriteInstr && !ioReadInstr && instrAddr == 8'h01
      |-> ##2 pinOut[15:8] == $past(accIn, 2)) else $error("write");
  AST_WR_INDEX:
    assert property (indexedIoWriteInstr && !ioReadInstr && !ioWriteInstr
      && instrAddr != 8'h00 && instrAddr + indexReg == 8'h04
      |-> ##2 pinIrqEnable[7:0] == $past(accIn, 2)) else $error("idx");
  AST_WR_ZERO:
    assert property (indexedIoWriteInstr && !ioReadInstr && !ioWriteInstr
      && instrAddr == 8'h00 && indexReg == 8'h03
      |-> ##2 pinOut[31:24] == $past(accIn, 2)) else $error("idx zero");
  AST_IRQ_EN:
    assert property (ioWriteInstr && !ioReadInstr && instrAddr == 8'h06
      |-> ##2 pinIrqEnable[23:16] == $past(accIn, 2)) else $error("irq");
  AST_PAR_OUT:
    assert property ($past(rstn) && $past(assistedParallelPortEn) |->
      pinOut[22:18] == $past(assistedParallelPortOut)) else $error("par");
  AST_PAR_IN:
    assert property ($past(rstn) |-> assistedParallelPortIn ==
      $past(pinIn[22:18])) else $error("par in");
  AST_WO_READ:
    assert property (ioReadInstr && instrAddr inside {[8'h04:8'h07]}
      |=> accOut == 8'h00) else $error("wo read");
endmodule
`default_nettype wire

// ---- tb/iop_core_model.sv ----
// Purpose: core issuing I/O instructions
// Assumes: one instruction at a time
// Notes: operands are inverted once released
`timescale 1ns/1ps
`default_nettype none
module iop_core_model (
  input wire logic clk,
  output var logic ioReadInstr,
  output var logic ioWriteInstr,
  output var logic indexedIoWriteInstr,
  output var iop_pkg::iop_byte_t instrAddr,
  output var iop_pkg::iop_byte_t indexReg,
  output var iop_pkg::iop_byte_t accIn
);
  import iop_pkg::*;
  // idle at time zero
  initial begin
    {ioReadInstr, ioWriteInstr, indexedIoWriteInstr} = 3'h0;
    {instrAddr, indexReg, accIn} = 24'h0;
  end
  // one instruction, strobe for one cycle
  // full bytes, defined places
  task automatic op(input iop_op_t k, input iop_byte_t a, x, v);
    @(posedge clk) #1;
    ioReadInstr = (k == IOP_OP_READ);
    ioWriteInstr = (k == IOP_OP_WRITE);
    indexedIoWriteInstr = (k == IOP_OP_IDXWRITE);
    {instrAddr, indexReg, accIn} = {a, x, v};
    @(posedge clk) #1;
    {ioReadInstr, ioWriteInstr, indexedIoWriteInstr} = 3'h0;
    {instrAddr, indexReg, accIn} = ~{instrAddr, indexReg, accIn};
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench of iop_regs
// Assumes: core model drives the strobes
// Notes: checker bound below
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import iop_pkg::*;
  logic clk, rstn, ioReadInstr, ioWriteInstr, indexedIoWriteInstr;
  iop_byte_t instrAddr, indexReg, accIn, accOut;
  logic accLoad, assistedParallelPortEn;
  logic [31:0] pinIn, pinOut, pinIrqEnable;
  logic [4:0] assistedParallelPortOut, assistedParallelPortIn;
  int fails, n_tests;
  iop_core_model core (
    .clk                 (clk),
    .ioReadInstr         (ioReadInstr),
    .ioWriteInstr        (ioWriteInstr),
    .indexedIoWriteInstr (indexedIoWriteInstr),
    .instrAddr           (instrAddr),
    .indexReg            (indexReg),
    .accIn               (accIn)
  );
  iop_regs dut (
    .clk                     (clk),
    .rstn                    (rstn),
    .ioReadInstr             (ioReadInstr),
    .ioWriteInstr            (ioWriteInstr),
    .indexedIoWriteInstr     (indexedIoWriteInstr),
    .instrAddr               (instrAddr),
    .indexReg                (indexReg),
    .accIn                   (accIn),
    .accOut                  (accOut),
    .accLoad                 (accLoad),
    .pinIn                   (pinIn),
    .pinOut                  (pinOut),
    .pinIrqEnable            (pinIrqEnable),
    .assistedParallelPortEn  (assistedParallelPortEn),
    .assistedParallelPortOut (assistedParallelPortOut),
    .assistedParallelPortIn  (assistedParallelPortIn)
  );
  // clock
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic chk(string nm, logic [31:0] e, g);
    n_tests++;
    if (e !== g) begin
      fails++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rd(iop_byte_t a, logic [7:0] e);
    core.op(IOP_OP_READ, a, 8'h00, 8'h00);
    chk("load", 1, accLoad);
    chk("rdata", e, accOut);
  endtask
  task automatic t_data;
    for (int i = 0; i < 4; i++) begin
      core.op(IOP_OP_WRITE, i[7:0], 8'h00, 8'h5a ^ i[7:0]);
      // pins show the stored byte one edge after the strobe edge
      @(posedge clk) #1;
      chk("pin", 8'h5a ^ i[7:0], pinOut[8*i+:8]);
    end
    for (int i = 0; i < 4; i++) rd(i[7:0], 8'h5a ^ i[7:0]);
  endtask
  task automatic t_irq;
    for (int i = 0; i < 4; i++) begin
      core.op(IOP_OP_WRITE, 8'h04 + i[7:0], 8'h00, 8'hc0 | i[7:0]);
      rd(8'h04 + i[7:0], 8'h00);
      chk("ien", 8'hc0 | i[7:0], pinIrqEnable[8*i+:8]);
    end
  endtask
  task automatic t_idx;
    core.op(IOP_OP_IDXWRITE, 8'h00, 8'h03, 8'ha5);
    @(posedge clk) #1;
    chk("idx0", 8'ha5, pinOut[31:24]);
    core.op(IOP_OP_IDXWRITE, 8'hff, 8'h05, 8'h3c);
    @(posedge clk) #1;
    chk("wrap", 8'h3c, pinIrqEnable[7:0]);
  endtask
  task automatic t_par;
    @(posedge clk) #1;
    {assistedParallelPortEn, assistedParallelPortOut} = 6'h35;
    pinIn = 32'h007c0000;
    repeat (2) @(posedge clk);
    #1;
    chk("pout", 5'h15, pinOut[22:18]);
    chk("p2", 3'h0, {pinOut[23], pinOut[17:16]});
    chk("pin", 5'h1f, assistedParallelPortIn);
    assistedParallelPortEn = 0;
    repeat (2) @(posedge clk);
    #1;
    chk("gpio", 5'h16, pinOut[22:18]);
  endtask
  // watchdog
  initial begin
    #8000;
    fails++;
    final_report;
  end
  // main sequence
  initial begin
    {rstn, assistedParallelPortEn, assistedParallelPortOut} = 7'h0;
    pinIn = 32'h0;
    repeat (20) @(posedge clk);
    #1 rstn = 1;
    chk("rst pin", 0, pinOut);
    chk("rst ien", 0, pinIrqEnable);
    chk("rst acc", 0, accOut);
    chk("rst load", 0, accLoad);
    chk("rst par", 0, assistedParallelPortIn);
    t_data;
    t_irq;
    t_idx;
    t_par;
    final_report;
  end
endmodule
bind iop_regs iop_regs_chk chk (
  .clk                     (clk),
  .rstn                    (rstn),
  .ioReadInstr             (ioReadInstr),
  .ioWriteInstr            (ioWriteInstr),
  .indexedIoWriteInstr     (indexedIoWriteInstr),
  .instrAddr               (instrAddr),
  .indexReg                (indexReg),
  .accIn                   (accIn),
  .accOut                  (accOut),
  .accLoad                 (accLoad),
  .pinIn                   (pinIn),
  .pinOut                  (pinOut),
  .pinIrqEnable            (pinIrqEnable),
  .assistedParallelPortEn  (assistedParallelPortEn),
  .assistedParallelPortOut (assistedParallelPortOut),
  .assistedParallelPortIn  (assistedParallelPortIn)
);
`default_nettype wire
